// file: hdl/sdl_decimator.sv
`timescale 1ns/1ns
module sdl_decimator (
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic                  enable_in,
    output logic        [15:0]         word_out,
    output logic                       word_valid_out,
    sdl_link_if.host                   link
);
    // ------------------------------------------------------------------
    // Sample clock generation
    // ------------------------------------------------------------------
    logic [sdl_pkg::SCLK_CNT_W-1:0] div_q;
    logic                           sclk_q;
    sdl_pkg::sdl_state_type         state_q;
    wire div_wrap = (div_q == sdl_pkg::SCLK_CNT_W'(sdl_pkg::SCLK_HALF_CYC - 1));
    wire run      = (state_q == sdl_pkg::SDL_ST_RUN);
    wire sclk_rise = div_wrap & ~sclk_q & run;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            state_q <= sdl_pkg::SDL_ST_IDLE;
            div_q   <= '0;
            sclk_q  <= 1'b0;
        end else begin
            unique case (state_q)
                sdl_pkg::SDL_ST_IDLE: begin
                    if (enable_in) state_q <= sdl_pkg::SDL_ST_RUN;
                end
                sdl_pkg::SDL_ST_RUN: begin
                    if (!enable_in && !sclk_q) state_q <= sdl_pkg::SDL_ST_IDLE;
                end
            endcase
            div_q <= div_wrap ? '0 : div_q + 1'b1;
            if (div_wrap && run) sclk_q <= ~sclk_q;
        end
    end
    assign link.sample_clock = sclk_q;

    // ------------------------------------------------------------------
    // Bit synchronised every system clock, two flops from the pin
    // ------------------------------------------------------------------
    logic bit_meta_q;
    logic bit_sync_q;
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            bit_meta_q <= 1'b0;
            bit_sync_q <= 1'b0;
        end else begin
            bit_meta_q <= link.modulator_bit;
            bit_sync_q <= bit_meta_q;
        end
    end

    // ------------------------------------------------------------------
    // Sinc3 integrators, one input per sample clock
    // ------------------------------------------------------------------
    localparam int unsigned W = sdl_pkg::ACC_W;
    logic [W-1:0] acc_q [3];
    // One maps to +1, zero to -1
    wire  [W-1:0] in_unit = bit_sync_q ? W'(1) : {W{1'b1}};

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            acc_q[0] <= '0;
            acc_q[1] <= '0;
            acc_q[2] <= '0;
        end else if (sclk_rise) begin
            acc_q[0] <= acc_q[0] + in_unit;
            acc_q[1] <= acc_q[1] + acc_q[0];
            acc_q[2] <= acc_q[2] + acc_q[1];
        end
    end

    // ------------------------------------------------------------------
    // Decimation and combs
    // ------------------------------------------------------------------
    logic [sdl_pkg::DEC_CNT_W-1:0] cnt_q;
    logic [W-1:0] d1_q, d2_q, d3_q;
    wire          dec_tick = sclk_rise && (cnt_q == sdl_pkg::DEC_LAST);
    wire  [W-1:0] c1_d = acc_q[2] - d1_q;
    wire  [W-1:0] c2_d = c1_d - d2_q;
    wire  [W-1:0] c3_d = c2_d - d3_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            cnt_q          <= '0;
            d1_q           <= '0;
            d2_q           <= '0;
            d3_q           <= '0;
            word_out       <= '0;
            word_valid_out <= 1'b0;
        end else begin
            word_valid_out <= dec_tick;
            if (sclk_rise) cnt_q <= cnt_q + 1'b1;
            if (dec_tick) begin
                d1_q     <= acc_q[2];
                d2_q     <= c1_d;
                d3_q     <= c2_d;
                word_out <= c3_d[sdl_pkg::WORD_LSB +: sdl_pkg::WORD_W];
            end
        end
    end

endmodule // sdl_decimator

// file: hdl/sdl_pkg.sv
package sdl_pkg;

    // ------------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------------
    localparam int unsigned SYS_CLK_HZ        = 50_000_000;
    localparam int unsigned MAX_BIT_RATE_HZ   = 20_000_000;
    localparam int unsigned NOM_BIT_RATE_HZ   = 16_000_000;
    // Sample clock half period in system clocks; host divides its clock
    localparam int unsigned SCLK_HALF_CYC     = 2;
    localparam int unsigned SCLK_CNT_W        = 2;

    // ------------------------------------------------------------------
    // Modulator
    // ------------------------------------------------------------------
    localparam int unsigned IN_W              = 16;
    localparam int unsigned INT_W             = 20;
    // Input full scale maps to +/-FB_POS, feedback equal to full scale
    localparam logic signed [INT_W-1:0] FB_POS = 20'sh0_7FFF;
    localparam logic signed [INT_W-1:0] FB_NEG = -20'sh0_7FFF;
    localparam logic signed [INT_W-1:0] INT_MAX = 20'sh3_FFFF;
    localparam logic signed [INT_W-1:0] INT_MIN = -20'sh3_FFFF;

    // ------------------------------------------------------------------
    // Decimator
    // ------------------------------------------------------------------
    localparam int unsigned DEC_RATE          = 256;
    localparam int unsigned DEC_CNT_W         = 8;
    localparam int unsigned ACC_W             = 25;
    localparam int unsigned WORD_W            = 16;
    localparam int unsigned WORD_LSB          = 9;
    localparam logic [DEC_CNT_W-1:0] DEC_LAST = 8'hFF;

    typedef enum logic [1:0] {
        SDL_ST_IDLE = 2'b01,
        SDL_ST_RUN  = 2'b10
    } sdl_state_type;

endpackage

// file: hdl/sdl_link_if.sv
`timescale 1ns/1ns
interface sdl_link_if;
    logic sample_clock;
    logic modulator_bit;

    modport device (input sample_clock, output modulator_bit);
    modport host   (output sample_clock, input modulator_bit);
endinterface

// file: hdl/sdl_modulator.sv
`timescale 1ns/1ns
// Operation
// - one bit per sample clock period
// - host supplies the sample clock
// - ones density proportional to input
// - zero input gives runs of four ones, four zeros
// - positive input raises density above half
// - negative input lowers density below half
// - positive full scale gives all ones
// - host filters with third order sinc
// - decimate 256 gives 16-bit words
// - host picks decimation rate tradeoff
// - launch on rise, capture next rise
module sdl_modulator (
    input  wire logic                  clock_in,
    input  wire logic                  rst_n_in,
    input  wire logic signed [15:0]    sample_value_in,
    sdl_link_if.device                 link
);
    // ------------------------------------------------------------------
    // Sample clock synchroniser and rising edge
    // ------------------------------------------------------------------
    logic sclk_meta_q;
    logic sclk_sync_q;
    logic sclk_prev_q;
    wire  sclk_rise = sclk_sync_q & ~sclk_prev_q;

    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            sclk_meta_q <= 1'b0;
            sclk_sync_q <= 1'b0;
            sclk_prev_q <= 1'b0;
        end else begin
            sclk_meta_q <= link.sample_clock;
            sclk_sync_q <= sclk_meta_q;
            sclk_prev_q <= sclk_sync_q;
        end
    end

    // ------------------------------------------------------------------
    // Second order loop
    // ------------------------------------------------------------------
    logic signed [sdl_pkg::INT_W-1:0] int1_q;
    logic signed [sdl_pkg::INT_W-1:0] int2_q;
    logic                             bit_q;

    // Full-scale input saturates the loop to a constant stream
    wire signed [sdl_pkg::INT_W-1:0] in_ext = sdl_pkg::INT_W'(sample_value_in);
    wire signed [sdl_pkg::INT_W-1:0] fb     = bit_q ? sdl_pkg::FB_POS
                                                    : sdl_pkg::FB_NEG;
    wire signed [sdl_pkg::INT_W+1:0] sum1   = (sdl_pkg::INT_W+2)'(int1_q)
                                              + (sdl_pkg::INT_W+2)'(in_ext)
                                              - (sdl_pkg::INT_W+2)'(fb);
    wire signed [sdl_pkg::INT_W+1:0] sum2   = (sdl_pkg::INT_W+2)'(int2_q)
                                              + (sdl_pkg::INT_W+2)'(int1_q)
                                              - (sdl_pkg::INT_W+2)'(fb);
    wire signed [sdl_pkg::INT_W-1:0] int1_d = sat(sum1);
    wire signed [sdl_pkg::INT_W-1:0] int2_d = sat(sum2);
    // Sign of second integrator decides the bit; zero input gives runs of four ones, four zeros
    wire bit_d = ~int2_d[sdl_pkg::INT_W-1];

    function automatic logic signed [sdl_pkg::INT_W-1:0] sat(
        input logic signed [sdl_pkg::INT_W+1:0] v);
        if (v > (sdl_pkg::INT_W+2)'(sdl_pkg::INT_MAX))
            sat = sdl_pkg::INT_MAX;
        else if (v < (sdl_pkg::INT_W+2)'(sdl_pkg::INT_MIN))
            sat = sdl_pkg::INT_MIN;
        else
            sat = v[sdl_pkg::INT_W-1:0];
    endfunction

    // One new bit launched per sample clock rising edge
    always_ff @(posedge clock_in) begin
        if (!rst_n_in) begin
            int1_q <= '0;
            int2_q <= '0;
            bit_q  <= 1'b0;
        end else if (sclk_rise) begin
            int1_q <= int1_d;
            int2_q <= int2_d;
            bit_q  <= bit_d;
        end
    end

    assign link.modulator_bit = bit_q;

endmodule // sdl_modulator

// file: verification/sdl_link_chk.sv
`timescale 1ns/1ns
// --------------------------------
// Link wire checks
// --------------------------------
module sdl_link_chk (
    input wire logic clock_in,
    input wire logic rst_n_in,
    input wire logic sample_clock,
    input wire logic modulator_bit
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_high_phase;
        sample_clock [*2] ##1 !sample_clock;
    endsequence
    sequence s_bit_held;
        $stable(modulator_bit) [*3];
    endsequence
    chk_clk_high_len: assert property ($rose(sample_clock) |-> s_high_phase)
        else $error("sample clock high phase length");
    chk_clk_low_len: assert property ($fell(sample_clock) |-> !sample_clock [*2])
        else $error("sample clock low phase too short");
    chk_low_before_rise: assert property ($rose(sample_clock) |-> !$past(sample_clock, 2))
        else $error("sample clock rose after short low");
    chk_bit_after_rise: assert property ($changed(modulator_bit) |->
            !sample_clock && $past(sample_clock, 2))
        else $error("bit changed away from launch point");
    chk_bit_stands: assert property ($changed(modulator_bit) |=> s_bit_held)
        else $error("bit did not stand a sample period");
    chk_bit_holds_rise: assert property ($rose(sample_clock) |=> $stable(modulator_bit))
        else $error("bit moved at capture edge");
    chk_clk_reset_idle: assert property ($rose(rst_n_in) |-> !sample_clock)
        else $error("sample clock not idle after reset");
    chk_bit_reset_zero: assert property ($rose(rst_n_in) |-> !modulator_bit)
        else $error("bit not zero after reset");
endmodule // sdl_link_chk

// file: verification/sigma_delta_bitstream_link_test.sv
`timescale 1ns/1ns
module sigma_delta_bitstream_link_test;
    logic               clock_in;
    logic               rst_n_in;
    logic               enable_in;
    logic signed [15:0] sample_value_in;
    logic        [15:0] word_out;
    logic               word_valid_out;
    logic               sc_q = 1'b0;
    int                 err_count = 0;
    int                 n_checks = 0;
    int                 ones = 0;
    int                 rises = 0;
    int                 total = 0;
    int                 last = 0;
    int                 cycles = 0;
    sdl_link_if link ();
    sdl_modulator sdl_modulator_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .sample_value_in(sample_value_in), .link(link));
    sdl_decimator sdl_decimator_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .enable_in(enable_in), .word_out(word_out), .word_valid_out(word_valid_out),
        .link(link));
    sdl_link_chk sdl_link_chk_i (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .sample_clock(link.sample_clock), .modulator_bit(link.modulator_bit));
    // --------------------------------
    // Checks and verdict
    // --------------------------------
    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check_count(input int got, input int exp, input int tol);
        n_checks++;
        if (got < exp - tol || got > exp + tol) begin
            err_count++;
            $display("wrong value at %0t: count %0d not %0d", $time, got, exp);
        end
    endtask
    task automatic check_word(input logic [15:0] got, input int exp);
        n_checks++;
        if ($isunknown(got) || $signed(got) < exp - 512 || $signed(got) > exp + 512) begin
            err_count++;
            $display("wrong value at %0t: word %0d not %0d", $time, $signed(got), exp);
        end
    endtask
    // Hold a level, then count the bits captured at sample clock rises
    task automatic run_level(input int v, input int exp, input int tol, input bit word);
        sample_value_in = 16'(v);
        repeat (3200) @(posedge clock_in);
        #1 ones = 0;
        rises = 0;
        repeat (1024) @(posedge clock_in);
        #1 check_count(rises, 256, 0);
        check_count(ones, exp, tol);
        if (word) check_word(word_out, v);
    endtask
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        sc_q <= link.sample_clock;
        if (link.sample_clock && !sc_q) begin
            rises <= rises + 1;
            total <= total + 1;
            ones <= ones + int'(link.modulator_bit);
            if ($isunknown(link.modulator_bit)) begin
                err_count++;
                $display("wrong value at %0t: bit unknown at sample rise", $time);
            end
        end
        if (word_valid_out === 1'b1) begin
            if (last > 0) check_count(total - last, sdl_pkg::DEC_RATE, 0);
            last <= total;
        end
        if (cycles == 60000) begin
            err_count++;
            results();
        end
    end
    initial begin
        clock_in = 1'b0;
        forever #10 clock_in = ~clock_in;
    end
    initial begin
        rst_n_in = 1'b0;
        enable_in = 1'b0;
        sample_value_in = 16'sh0000;
        repeat (12) @(posedge clock_in);
        #1 rst_n_in = 1'b1;
        @(posedge clock_in);
        #1 enable_in = 1'b1;
        run_level(0, 128, 2, 1'b1);
        run_level(20479, 208, 4, 1'b1);
        run_level(25599, 228, 4, 1'b1);
        run_level(-20479, 48, 4, 1'b1);
        run_level(-25599, 28, 4, 1'b1);
        run_level(32767, 256, 1, 1'b0);
        run_level(-32767, 0, 1, 1'b0);
        enable_in = 1'b0;
        repeat (8) @(posedge clock_in);
        #1 rises = 0;
        repeat (400) @(posedge clock_in);
        #1 check_count(rises, 0, 0);
        results();
    end
endmodule // sigma_delta_bitstream_link_test
